//--- hdl/mps_pkg.sv
// constants and types shared by the module power sequencer
package mps_pkg;

  // ==========================================================
  // clock rate and timing figures
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned ON_HOLD_MS    = 1000;   // power-on press, least
  localparam int unsigned OFF_HOLD_MS   = 2500;   // hardware shutdown press, least
  localparam int unsigned EMRG_HOLD_MS  = 200;    // emergency-off press, least
  localparam int unsigned OPER_MIN_MS   = 20000;  // no readiness before this
  localparam int unsigned PMON_TYP_MS   = 21000;  // default variant group
  localparam int unsigned SWRDY_TYP_MS  = 28000;
  localparam int unsigned DETACH_MS     = 100;    // detach request pulse length
  localparam int unsigned FINAL_MS      = 15000;  // finalization duration

  localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;
  localparam int unsigned ON_HOLD_CYC   = ON_HOLD_MS * CYC_PER_MS;
  localparam int unsigned OFF_HOLD_CYC  = OFF_HOLD_MS * CYC_PER_MS;
  localparam int unsigned EMRG_HOLD_CYC = EMRG_HOLD_MS * CYC_PER_MS;
  localparam int unsigned OPER_MIN_CYC  = OPER_MIN_MS * CYC_PER_MS;
  localparam int unsigned PMON_CYC      = PMON_TYP_MS * CYC_PER_MS;
  localparam int unsigned SWRDY_CYC     = SWRDY_TYP_MS * CYC_PER_MS;
  localparam int unsigned DETACH_CYC    = DETACH_MS * CYC_PER_MS;
  localparam int unsigned FINAL_CYC     = FINAL_MS * CYC_PER_MS;

  localparam int unsigned CNT_W         = 32;

  // ==========================================================
  // sequencer states
  typedef enum logic [2:0] {
    MPS_OFF      = 3'b000,
    MPS_BOOT     = 3'b001,
    MPS_PADS_OK  = 3'b010,
    MPS_READY    = 3'b011,
    MPS_DETACH   = 3'b100,
    MPS_FINAL    = 3'b101
  } mps_state_t;

  // status outputs travel together
  typedef struct packed {
    logic power_monitor;
    logic software_ready;
    logic auxiliary_supply_out;
    logic detach_request;
  } mps_status_t;

  localparam mps_status_t MPS_STATUS_RST = 4'h0;

endpackage

//--- hdl/mps_press_timer.sv
// low-level press timer for an active-low pad
`timescale 1ns/1ps
module mps_press_timer
  import mps_pkg::*;
#(
  parameter int unsigned HOLD_CYC = 100
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // synchronised pad level, active low
  input  wire logic pad_n,
  // held past the least time, level while still pressed
  output logic      held,
  // one-cycle pulse on release after a long enough press
  output logic      released
);

  logic [CNT_W-1:0] cnt_ff;
  logic             pad_d_ff;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 32'h0;
    end else if (pad_n) begin
      cnt_ff <= 32'h0;
    end else if (cnt_ff < HOLD_CYC) begin
      cnt_ff <= cnt_ff + 32'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pad_d_ff <= 1'b1;
    end else begin
      pad_d_ff <= pad_n;
    end
  end

  assign held     = !pad_n && (cnt_ff >= HOLD_CYC);
  assign released = pad_n && !pad_d_ff && (cnt_ff >= HOLD_CYC);

endmodule

//--- hdl/mps_sequencer.sv
// power-on, initialization and power-off sequencing of a modem module
`timescale 1ns/1ps
// Summary of operation
// - After power-on the module boots and stays inaccessible until boot has finished.
// - The module is never operational earlier than twenty seconds after the toggle pad went low.
// - Software-ready goes high once power-up is complete and commands are accepted.
// - Power-monitor goes high once all pads are configured during initialization.
// - Power-monitor and software-ready delays follow the variant group: 21/28, 13/16 or 10/20 s.
// - With the toggle pad tied to ground, power-on starts right after battery supply comes up.
// - Power-off is shown by power-monitor and software-ready both low.
// - Power-off comes from a soft command, a long toggle-pad press, the emergency-off pad, or loss of battery supply.
// - Soft command and toggle-pad shutdown send a network detach first; emergency-off does not.
module mps_sequencer
  import mps_pkg::*;
#(
  parameter int unsigned ON_CYC     = ON_HOLD_CYC,
  parameter int unsigned OFF_CYC    = OFF_HOLD_CYC,
  parameter int unsigned EMRG_CYC   = EMRG_HOLD_CYC,
  parameter int unsigned OPER_CYC   = OPER_MIN_CYC,
  parameter int unsigned PMON_DLY   = PMON_CYC,
  parameter int unsigned SWRDY_DLY  = SWRDY_CYC,
  parameter int unsigned DETACH_DLY = DETACH_CYC,
  parameter int unsigned FINAL_DLY  = FINAL_CYC
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic resetn,
  // supply and pads from the host
  input  wire logic battery_supply,
  input  wire logic power_toggle_n,
  input  wire logic emergency_off_n,
  // soft shutdown request from module firmware, same clock
  input  wire logic soft_off_command,
  // status to the host
  output logic      power_monitor,
  output logic      software_ready,
  output logic      auxiliary_supply_out,
  output logic      detach_request,
  output logic      command_accept
);

  // ==========================================================
  // reset release and pad synchronisers
  logic [1:0] rst_sync_ff;
  logic       rst_n;
  logic [1:0] batt_sync_ff;
  logic [1:0] tog_sync_ff;
  logic [1:0] emrg_sync_ff;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // pads idle at their pulled-up level so reset never looks like a press
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      batt_sync_ff <= 2'h0;
      tog_sync_ff  <= 2'h3;
      emrg_sync_ff <= 2'h3;
    end else begin
      batt_sync_ff <= {batt_sync_ff[0], battery_supply};
      tog_sync_ff  <= {tog_sync_ff[0], power_toggle_n};
      emrg_sync_ff <= {emrg_sync_ff[0], emergency_off_n};
    end
  end

  // ==========================================================
  // press timers
  logic on_held;
  logic on_rel;
  logic off_rel;
  logic emrg_rel;
  logic emrg_held;

  mps_press_timer #(.HOLD_CYC(ON_CYC)) u_on_timer (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .pad_n    (tog_sync_ff[1]),
    .held     (on_held),
    .released (on_rel)
  );

  mps_press_timer #(.HOLD_CYC(OFF_CYC)) u_off_timer (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .pad_n    (tog_sync_ff[1]),
    .held     (),
    .released (off_rel)
  );

  mps_press_timer #(.HOLD_CYC(EMRG_CYC)) u_emrg_timer (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .pad_n    (emrg_sync_ff[1]),
    .held     (emrg_held),
    .released (emrg_rel)
  );

  // ==========================================================
  // state machine
  mps_state_t       state_ff;
  mps_state_t       nxt_state;
  logic [CNT_W-1:0] time_ff;
  logic [CNT_W-1:0] nxt_time;
  logic             batt_ok;
  logic             tied_start;
  logic             kill;
  logic             swrdy_due;

  assign batt_ok = batt_sync_ff[1];
  // a pad tied low with the supply present acts as a press once it passes the least time
  assign tied_start = on_held;
  assign kill = emrg_rel || emrg_held || !batt_ok;
  // readiness waits for both its typical delay and the least operational time
  assign swrdy_due = (time_ff >= SWRDY_DLY) && (time_ff >= OPER_CYC);

  always_comb begin
    nxt_state = state_ff;
    nxt_time  = (time_ff == 32'hFFFFFFFF) ? time_ff : time_ff + 32'h1;
    unique case (state_ff)
      MPS_OFF: begin
        nxt_time = 32'h0;
        // time counts from the press start, so preload the hold already elapsed
        if (batt_ok && (on_rel || tied_start)) begin
          nxt_state = MPS_BOOT;
          nxt_time  = ON_CYC;
        end
      end
      MPS_BOOT: begin
        if (time_ff >= PMON_DLY) begin
          nxt_state = MPS_PADS_OK;
        end
      end
      MPS_PADS_OK: begin
        if (swrdy_due) begin
          nxt_state = MPS_READY;
        end
      end
      MPS_READY: begin
        if (soft_off_command || off_rel) begin
          nxt_state = MPS_DETACH;
          nxt_time  = 32'h0;
        end
      end
      MPS_DETACH: begin
        if (time_ff >= DETACH_DLY) begin
          nxt_state = MPS_FINAL;
          nxt_time  = 32'h0;
        end
      end
      MPS_FINAL: begin
        if (time_ff >= FINAL_DLY) begin
          nxt_state = MPS_OFF;
          nxt_time  = 32'h0;
        end
      end
      default: begin
        nxt_state = MPS_OFF;
        nxt_time  = 32'h0;
      end
    endcase
    // emergency path skips detach and finalization entirely
    if (kill && state_ff != MPS_OFF) begin
      nxt_state = MPS_OFF;
      nxt_time  = 32'h0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= MPS_OFF;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      time_ff <= 32'h0;
    end else begin
      time_ff <= nxt_time;
    end
  end

  // ==========================================================
  // registered outputs, decoded from the next state to avoid a lag
  mps_status_t stat_ff;
  mps_status_t nxt_stat;
  logic        accept_ff;

  always_comb begin
    nxt_stat = MPS_STATUS_RST;
    nxt_stat.power_monitor        = (nxt_state != MPS_OFF) && (nxt_state != MPS_BOOT);
    nxt_stat.auxiliary_supply_out = nxt_stat.power_monitor;
    nxt_stat.software_ready       = (nxt_state == MPS_READY);
    nxt_stat.detach_request       = (nxt_state == MPS_DETACH);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_ff <= MPS_STATUS_RST;
    end else begin
      stat_ff <= nxt_stat;
    end
  end

  // commands are only taken once ready; earlier ones fall on the floor
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      accept_ff <= 1'b0;
    end else begin
      accept_ff <= (nxt_state == MPS_READY);
    end
  end

  assign power_monitor        = stat_ff.power_monitor;
  assign software_ready       = stat_ff.software_ready;
  assign auxiliary_supply_out = stat_ff.auxiliary_supply_out;
  assign detach_request       = stat_ff.detach_request;
  assign command_accept       = accept_ff;

endmodule

//--- verification/mps_seq_properties.sv
// concurrent checks on the module power sequencer ports
`timescale 1ns/1ps
module mps_seq_properties (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // pads and request
  input wire logic battery_supply,
  input wire logic power_toggle_n,
  input wire logic emergency_off_n,
  input wire logic soft_off_command,
  // status
  input wire logic power_monitor,
  input wire logic software_ready,
  input wire logic auxiliary_supply_out,
  input wire logic detach_request,
  input wire logic command_accept
);
  // ==========================================================
  // sequences and properties
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  sequence s_off;
    !power_monitor && !software_ready && !detach_request;
  endsequence
  // finalization keeps the power monitor up until the module is really off
  sequence s_final;
    !detach_request && power_monitor && !software_ready;
  endsequence
  // detach length fixed by the bench's DETACH_DLY of 4
  sequence s_detach;
    detach_request [*5] ##1 s_final;
  endsequence
  a_aux_tracks_pmon: assert property (auxiliary_supply_out == power_monitor)
    else $error("aux supply differs from power monitor");
  a_accept_tracks_ready: assert property (command_accept == software_ready)
    else $error("command accept differs from software ready");
  a_pmon_leads_ready: assert property ($rose(software_ready) |-> $past(power_monitor, 8))
    else $error("software ready without earlier power monitor");
  a_detach_status: assert property (detach_request |-> power_monitor && !software_ready)
    else $error("wrong status during detach");
  a_detach_shape: assert property ($rose(detach_request) |-> s_detach)
    else $error("detach pulse has wrong length");
  a_detach_from_ready: assert property ($rose(detach_request) |-> $past(software_ready))
    else $error("detach not entered from ready");
  a_final_pmon_held: assert property ($fell(detach_request) |-> power_monitor [*8])
    else $error("power monitor dropped during finalization");
  a_soft_off_acts: assert property (software_ready && soft_off_command |-> ##[1:3] detach_request)
    else $error("soft off not acted on");
  a_emerg_kills: assert property (!emergency_off_n [*8] |-> ##[0:4] s_off)
    else $error("emergency off ignored");
  a_battery_kills: assert property (!battery_supply [*3] |-> ##[0:2] s_off)
    else $error("outputs high without supply");
endmodule
bind mps_sequencer mps_seq_properties i_props (.sys_clk, .resetn, .battery_supply,
  .power_toggle_n, .emergency_off_n, .soft_off_command, .power_monitor, .software_ready,
  .auxiliary_supply_out, .detach_request, .command_accept);

//--- verification/mps_host_model.sv
// host-side model driving the power pads open-collector style
`timescale 1ns/1ps
module mps_host_model (
  // clock
  input  wire logic sys_clk,
  // pads, released means pulled up inside the module
  output logic      power_toggle_n,
  output logic      emergency_off_n
);
  // ==========================================================
  // pad pulses
  initial begin
    power_toggle_n = 1'b1;
    emergency_off_n = 1'b1;
  end
  // pulses timed on the host clock; zero cycles ties the pad to ground
  task automatic press_toggle(input int cycles);
    @(negedge sys_clk);
    power_toggle_n = 1'b0;
    if (cycles > 0) begin
      repeat (cycles) @(negedge sys_clk);
      power_toggle_n = 1'b1;
    end
  endtask
  task automatic press_emergency(input int cycles);
    @(negedge sys_clk);
    emergency_off_n = 1'b0;
    repeat (cycles) @(negedge sys_clk);
    emergency_off_n = 1'b1;
  endtask
endmodule

//--- verification/mps_sequencer_tb.sv
// self-checking bench for the module power sequencer
`timescale 1ns/1ps
module mps_sequencer_tb;
  localparam int ON = 10;
  localparam int OFF = 25;
  localparam int EMRG = 5;
  localparam int OPER = 200;
  localparam int PMON = 210;
  localparam int SWRDY = 280;
  localparam int DET = 4;
  localparam int FIN = 20;
  localparam int LAT = 12;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic battery_supply = 1'b1;
  logic soft_off_command = 1'b0;
  logic power_toggle_n, emergency_off_n, power_monitor, software_ready;
  logic auxiliary_supply_out, detach_request, command_accept;
  logic [7:0] rnd = 8'h54;
  int fail_count = 0;
  int num_checks = 0;
  int cyc = 0;
  int n;
  always #5 sys_clk = ~sys_clk;
  mps_host_model i_host (.sys_clk, .power_toggle_n, .emergency_off_n);
  mps_sequencer #(.ON_CYC(ON), .OFF_CYC(OFF), .EMRG_CYC(EMRG), .OPER_CYC(OPER),
    .PMON_DLY(PMON), .SWRDY_DLY(SWRDY), .DETACH_DLY(DET), .FINAL_DLY(FIN)) i_dut (
    .sys_clk, .resetn, .battery_supply, .power_toggle_n, .emergency_off_n,
    .soft_off_command, .power_monitor, .software_ready, .auxiliary_supply_out,
    .detach_request, .command_accept);
  // ==========================================================
  // helpers
  function automatic logic [7:0] lfsr_next(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  function automatic int ready_at();
    return (SWRDY > OPER) ? SWRDY : OPER;
  endfunction
  task automatic check(input logic seen, input logic exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t seen %b expected %b", $time, seen, exp);
    end
  endtask
  // bounded wait: 0 monitor, 1 ready, 2 detach, 3 all low
  task automatic wait_for(input int sel, input int lim, output int k);
    k = 0;
    while (k < lim && !(sel == 0 ? power_monitor === 1'b1 : sel == 1 ?
        software_ready === 1'b1 : sel == 2 ? detach_request === 1'b1 :
        {power_monitor, software_ready, detach_request} === 3'b000)) begin
      @(negedge sys_clk);
      k++;
    end
  endtask
  task automatic power_on(input int len);
    int t0;
    t0 = cyc;
    i_host.press_toggle(len);
    wait_for(0, 400, n);
    check(cyc - t0 >= PMON && cyc - t0 <= PMON + LAT, 1'b1);
    check(command_accept, 1'b0);
    wait_for(1, 400, n);
    check(cyc - t0 >= ready_at() && cyc - t0 <= ready_at() + LAT, 1'b1);
    check(auxiliary_supply_out & command_accept, 1'b1);
  endtask
  task automatic shut_check(input logic det);
    wait_for(2, 12, n);
    check(n < 12, det);
    check(power_monitor, det);
    check(software_ready, 1'b0);
    wait_for(3, FIN + 2 * DET + 12, n);
    check(power_monitor | software_ready | detach_request, 1'b0);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ==========================================================
  // watchdog and scenarios
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 6000) begin
      fail_count++;
      complete_run();
    end
  end
  initial begin
    repeat (10) @(negedge sys_clk);
    resetn = 1'b1;
    repeat (4) @(negedge sys_clk);
    i_host.press_toggle(ON - 4);
    soft_off_command = 1'b1;
    @(negedge sys_clk);
    soft_off_command = 1'b0;
    repeat (60) @(negedge sys_clk);
    check(power_monitor | detach_request, 1'b0);
    $display("short press test done");
    power_on(ON + rnd[1:0]);
    rnd = lfsr_next(rnd);
    soft_off_command = 1'b1;
    @(negedge sys_clk);
    soft_off_command = 1'b0;
    shut_check(1'b1);
    $display("soft off test done");
    power_on(ON + rnd[1:0]);
    rnd = lfsr_next(rnd);
    i_host.press_toggle(OFF + rnd[2:0]);
    shut_check(1'b1);
    $display("toggle off test done");
    power_on(ON + rnd[1:0]);
    rnd = lfsr_next(rnd);
    i_host.press_emergency(EMRG + 7 + rnd[1:0]);
    shut_check(1'b0);
    $display("emergency off test done");
    power_on(0);
    battery_supply = 1'b0;
    wait_for(3, 10, n);
    check(n < 10, 1'b1);
    $display("tied pad test done");
    complete_run();
  end
endmodule
